// ===== hw/gp_top.sv
// gpio ports b, c, d with two external pin interrupts, apb slave.
// assumes an apb master on pclk and pads outside resolving out/oe/in.
`timescale 1ns/1ns

// Behaviour
// R1 - interrupt fires even with pin as output
// R2 - selectable falling, rising or low-level trigger
// R3 - low level requests while pin stays low
// R4 - edge detection runs on i/o clock
// R5 - low-level detection works without i/o clock
// R6 - no edge detection in deep sleep
// R7 - two watchdog samples of level to wake
// R8 - wake on samples or level until startup
// R9 - level gone before startup: wake, no request
// R10 - outside holds level until device awake
// R11 - latch and direction bits rw, reset zero
// R12 - pin registers read-only, show pin levels
// R13 - port c bit 7 reads zero
// R14 - sense field: low, any, fall, rise
// R15 - pulses over one clock always caught
// R16 - event sets flag, service or one clears
// R17 - request needs own and global enable
// R18 - synchronise interrupt pins before edge detection
// R19 - direction one drives pin from latch
module gp_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // port b pins
  input  wire logic [7:0]  port_b_pin_in,
  output logic      [7:0]  port_b_pin_out,
  output logic      [7:0]  port_b_pin_oe,
  // port c pins
  input  wire logic [6:0]  port_c_pin_in,
  output logic      [6:0]  port_c_pin_out,
  output logic      [6:0]  port_c_pin_oe,
  // port d pins
  input  wire logic [7:0]  port_d_pin_in,
  output logic      [7:0]  port_d_pin_out,
  output logic      [7:0]  port_d_pin_oe,
  // power state
  input  wire logic        io_clk_run,
  input  wire logic        deep_sleep,
  input  wire logic        startup_done,
  // interrupt service
  input  wire logic [1:0]  irq_ack,
  output logic             irq,
  output logic             wake
);
  import gp_pkg::*;

  // ==========================================================
  // state
  gp_top_state_t s_r;
  gp_top_state_t s_nxt;

  gp_irq_if irq_a_if ();
  gp_irq_if irq_b_if ();

  // ==========================================================
  // bus decode
  logic       acc;
  logic       wr_go;
  logic       rd_go;
  logic       mapped;
  logic [7:0] wbyte;
  logic [2:0] clr_bits;

  assign acc   = psel & penable & ~s_r.pready;
  assign wr_go = psel & penable & s_r.pready & pwrite & ~s_r.pslverr;
  assign rd_go = acc & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign clr_bits = (wr_go && paddr == `GP_ADDR_CLEAR) ? wbyte[2:0] : 3'b000;

  always_comb begin
    case (paddr)
      `GP_ADDR_B_LAT,
      `GP_ADDR_B_DIR,
      `GP_ADDR_B_PIN,
      `GP_ADDR_C_LAT,
      `GP_ADDR_C_DIR,
      `GP_ADDR_C_PIN,
      `GP_ADDR_D_LAT,
      `GP_ADDR_D_DIR,
      `GP_ADDR_D_PIN,
      `GP_ADDR_CPUCTL,
      `GP_ADDR_IRQ_EN,
      `GP_ADDR_STATUS,
      `GP_ADDR_CLEAR: mapped = 1'b1;
      default:        mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // read mux
  logic [7:0] status;
  logic [7:0] rbyte;

  always_comb begin
    status = `GP_ZERO8;
    status[`GP_ST_FLAG_A] = irq_a_if.flag;
    status[`GP_ST_FLAG_B] = irq_b_if.flag;
    status[`GP_ST_WAKE]   = s_r.wake_st;
  end

  always_comb begin
    rbyte = `GP_ZERO8;
    case (paddr)
      `GP_ADDR_B_LAT:  rbyte = s_r.b_lat;                      // R11
      `GP_ADDR_B_DIR:  rbyte = s_r.b_dir;                      // R11
      `GP_ADDR_B_PIN:  rbyte = port_b_pin_in;                  // R12
      `GP_ADDR_C_LAT:  rbyte = {1'b0, s_r.c_lat};              // R13
      `GP_ADDR_C_DIR:  rbyte = {1'b0, s_r.c_dir};              // R13
      `GP_ADDR_C_PIN:  rbyte = {1'b0, port_c_pin_in};          // R12 R13
      `GP_ADDR_D_LAT:  rbyte = s_r.d_lat;                      // R11
      `GP_ADDR_D_DIR:  rbyte = s_r.d_dir;                      // R11
      `GP_ADDR_D_PIN:  rbyte = port_d_pin_in;                  // R12
      `GP_ADDR_CPUCTL: rbyte = {4'h0, s_r.sense};
      `GP_ADDR_IRQ_EN: rbyte = s_r.en;
      `GP_ADDR_STATUS: rbyte = status;
      default:         rbyte = `GP_ZERO8;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;

    // bus answer: one wait cycle, data and error captured with pready
    s_nxt.pready  = acc;
    s_nxt.pslverr = acc & ~mapped;
    if (rd_go && mapped) begin
      s_nxt.prdata = {24'h00_0000, rbyte};
    end else if (acc) begin
      s_nxt.prdata = `GP_ZERO32;
    end

    // register writes land on the completing edge; pin registers ignore them
    if (wr_go) begin
      case (paddr)
        `GP_ADDR_B_LAT:  s_nxt.b_lat = wbyte;                  // R11
        `GP_ADDR_B_DIR:  s_nxt.b_dir = wbyte;                  // R11
        `GP_ADDR_C_LAT:  s_nxt.c_lat = wbyte[6:0];             // R11 R13
        `GP_ADDR_C_DIR:  s_nxt.c_dir = wbyte[6:0];             // R11 R13
        `GP_ADDR_D_LAT:  s_nxt.d_lat = wbyte;                  // R11
        `GP_ADDR_D_DIR:  s_nxt.d_dir = wbyte;                  // R11
        `GP_ADDR_CPUCTL: s_nxt.sense = wbyte[3:0];             // R14
        `GP_ADDR_IRQ_EN: s_nxt.en    = wbyte;
        default:         s_nxt.en    = s_r.en;
      endcase
    end

    // watchdog strobe divider, one strobe per nominal watchdog period
    if (s_r.tick_cnt == 6'(`GP_WDT_CYCLES - 1)) begin
      s_nxt.tick_cnt = 6'd0;
      s_nxt.tick     = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 6'd1;
      s_nxt.tick     = 1'b0;
    end

    // sticky wake event: a new wake beats a clear in the same cycle
    s_nxt.wake_st = (s_r.wake_st & ~clr_bits[`GP_ST_WAKE]) |
                    irq_a_if.wake | irq_b_if.wake;
    s_nxt.wake    = irq_a_if.wake | irq_b_if.wake;             // R8

    // one request line, gated by each enable and the global enable
    s_nxt.irq = s_r.en[`GP_EN_GLOBAL] &
                (|(status[2:0] & s_r.en[2:0]) |
                 irq_a_if.level_req | irq_b_if.level_req);    // R17 R3
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;                                               // R11
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // interrupt inputs
  // the sense units watch the pad level, not the latch, so an output pin
  // still raises its interrupt and software can trigger one itself
  assign irq_a_if.pin          = port_d_pin_in[`GP_PIN_IRQ_A];      // R1
  assign irq_a_if.sense        = s_r.sense[`GP_SENSE_A_LO +: 2];
  assign irq_a_if.enable       = s_r.en[`GP_EN_A];
  assign irq_a_if.io_run       = io_clk_run & ~deep_sleep;          // R6
  assign irq_a_if.deep_sleep   = deep_sleep;
  assign irq_a_if.wdt_tick     = s_r.tick;                          // R7
  assign irq_a_if.startup_done = startup_done;
  assign irq_a_if.flag_clr     = clr_bits[`GP_ST_FLAG_A] | irq_ack[0]; // R16

  assign irq_b_if.pin          = port_d_pin_in[`GP_PIN_IRQ_B];      // R1
  assign irq_b_if.sense        = s_r.sense[`GP_SENSE_B_LO +: 2];
  assign irq_b_if.enable       = s_r.en[`GP_EN_B];
  assign irq_b_if.io_run       = io_clk_run & ~deep_sleep;          // R6
  assign irq_b_if.deep_sleep   = deep_sleep;
  assign irq_b_if.wdt_tick     = s_r.tick;                          // R7
  assign irq_b_if.startup_done = startup_done;
  assign irq_b_if.flag_clr     = clr_bits[`GP_ST_FLAG_B] | irq_ack[1]; // R16

  gp_irq_sense u_sense_a (
    .pclk    (pclk),
    .presetn (presetn),
    .irq     (irq_a_if)
  );

  gp_irq_sense u_sense_b (
    .pclk    (pclk),
    .presetn (presetn),
    .irq     (irq_b_if)
  );

  // ==========================================================
  // outputs, all straight from flops
  assign prdata         = s_r.prdata;
  assign pready         = s_r.pready;
  assign pslverr        = s_r.pslverr;
  assign port_b_pin_out = s_r.b_lat;                             // R19
  assign port_b_pin_oe  = s_r.b_dir;                             // R19
  assign port_c_pin_out = s_r.c_lat;                             // R19
  assign port_c_pin_oe  = s_r.c_dir;                             // R19
  assign port_d_pin_out = s_r.d_lat;                             // R19
  assign port_d_pin_oe  = s_r.d_dir;                             // R19
  assign irq            = s_r.irq;
  assign wake           = s_r.wake;

endmodule // gp_top

// ===== hw/gp_defines.svh
// constants for the gpio port block: register byte addresses, field positions,
// reset values, sense codes and timing counts. definitions only.
`ifndef GP_DEFINES_SVH
`define GP_DEFINES_SVH

// ==========================================================
// register byte addresses
`define GP_ADDR_B_LAT   8'h00
`define GP_ADDR_B_DIR   8'h04
`define GP_ADDR_B_PIN   8'h08
`define GP_ADDR_C_LAT   8'h0C
`define GP_ADDR_C_DIR   8'h10
`define GP_ADDR_C_PIN   8'h14
`define GP_ADDR_D_LAT   8'h18
`define GP_ADDR_D_DIR   8'h1C
`define GP_ADDR_D_PIN   8'h20
`define GP_ADDR_CPUCTL  8'h24
`define GP_ADDR_IRQ_EN  8'h28
`define GP_ADDR_STATUS  8'h2C
`define GP_ADDR_CLEAR   8'h30

// ==========================================================
// widths, fields and reset values
`define GP_PORT_W       8
`define GP_PORT_C_OUTPUT_LATCH_W      7
`define GP_ZERO8        8'h00
`define GP_ZERO32       32'h0000_0000
`define GP_PIN_IRQ_A    2
`define GP_PIN_IRQ_B    3
`define GP_SENSE_A_LO   0
`define GP_SENSE_B_LO   2
`define GP_EN_A         0
`define GP_EN_B         1
`define GP_EN_WAKE      2
`define GP_EN_GLOBAL    7
`define GP_ST_FLAG_A    0
`define GP_ST_FLAG_B    1
`define GP_ST_WAKE      2

// ==========================================================
// sense codes
`define GP_SENSE_LOW    2'b00
`define GP_SENSE_ANY    2'b01
`define GP_SENSE_FALL   2'b10
`define GP_SENSE_RISE   2'b11

// ==========================================================
// timing
`define GP_CLK_PERIOD_NS 20
`define GP_WDT_PERIOD_NS 1000
`define GP_WDT_CYCLES    (`GP_WDT_PERIOD_NS / `GP_CLK_PERIOD_NS)
`define GP_TICK_W        6
`define GP_WAKE_SAMPLES  2'd2

`endif

// ===== hw/gp_pkg.sv
// types shared by the gpio port block.
// assumes gp_defines.svh sits beside it.
`include "gp_defines.svh"

package gp_pkg;

  // ==========================================================
  // trigger selection
  typedef enum logic [1:0] {
    GP_SNS_LOW  = `GP_SENSE_LOW,
    GP_SNS_ANY  = `GP_SENSE_ANY,
    GP_SNS_FALL = `GP_SENSE_FALL,
    GP_SNS_RISE = `GP_SENSE_RISE
  } gp_sense_t;

  // ==========================================================
  // state of one interrupt input
  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic       flag;
    logic [1:0] lvl_cnt;
    logic       wake;
  } gp_sns_state_t;

  // ==========================================================
  // state of the top
  typedef struct packed {
    logic [7:0]  b_lat;
    logic [7:0]  b_dir;
    logic [6:0]  c_lat;
    logic [6:0]  c_dir;
    logic [7:0]  d_lat;
    logic [7:0]  d_dir;
    logic [3:0]  sense;
    logic [7:0]  en;
    logic        wake_st;
    logic [5:0]  tick_cnt;
    logic        tick;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        wake;
  } gp_top_state_t;

endpackage

// ===== hw/gp_irq_if.sv
// signals between the top and one interrupt input sense unit.
// assumes one clock, pclk, on both sides.
`timescale 1ns/1ns

interface gp_irq_if;
  logic       pin;
  logic [1:0] sense;
  logic       enable;
  logic       io_run;
  logic       deep_sleep;
  logic       wdt_tick;
  logic       startup_done;
  logic       flag_clr;
  logic       flag;
  logic       level_req;
  logic       wake;

  modport ctl (output pin, sense, enable, io_run, deep_sleep, wdt_tick, startup_done, flag_clr,
               input flag, level_req, wake);
  modport sns (input pin, sense, enable, io_run, deep_sleep, wdt_tick, startup_done, flag_clr,
               output flag, level_req, wake);
endinterface

// ===== hw/gp_irq_sense.sv
// one external interrupt input: synchroniser, edge/level sense, flag, wake.
// assumes pin is the pad level and wdt_tick a one-cycle watchdog strobe.
`timescale 1ns/1ns

module gp_irq_sense (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control side
  gp_irq_if.sns    irq
);
  import gp_pkg::*;

  gp_sns_state_t s_r;
  gp_sns_state_t s_nxt;

  // ==========================================================
  // next state
  always_comb begin
    logic rise;
    logic fall;
    logic hit;
    logic lvl_mode;
    rise     = 1'b0;
    fall     = 1'b0;
    hit      = 1'b0;
    lvl_mode = (gp_sense_t'(irq.sense) == GP_SNS_LOW);
    s_nxt = s_r;
    s_nxt.sync1 = irq.pin;                               // R18
    s_nxt.sync2 = s_r.sync1;                             // R18
    s_nxt.prev  = s_r.sync2;
    rise = s_r.sync2 & ~s_r.prev;
    fall = ~s_r.sync2 & s_r.prev;
    case (gp_sense_t'(irq.sense))                        // R2 R14
      GP_SNS_ANY:  hit = rise | fall;                    // R15
      GP_SNS_FALL: hit = fall;
      GP_SNS_RISE: hit = rise;
      default:     hit = 1'b0;
    endcase
    // edges only count while the i/o clock runs
    hit = hit & irq.io_run;                              // R4 R6
    if (lvl_mode) begin
      s_nxt.flag = 1'b0;                                 // R16
    end else begin
      s_nxt.flag = (s_r.flag & ~irq.flag_clr) | hit;     // R16
    end
    // low level sampled on watchdog strobes, no i/o clock needed
    s_nxt.wake = 1'b0;
    if (irq.deep_sleep && irq.enable && lvl_mode) begin  // R5
      if (irq.wdt_tick) begin
        if (!s_r.sync2) begin
          if (s_r.lvl_cnt != `GP_WAKE_SAMPLES) begin
            s_nxt.lvl_cnt = s_r.lvl_cnt + 2'd1;          // R7
          end
        end else begin
          s_nxt.lvl_cnt = 2'd0;
        end
      end
      s_nxt.wake = (s_r.lvl_cnt == `GP_WAKE_SAMPLES) |
                   ((s_r.lvl_cnt != 2'd0) & irq.startup_done & ~s_r.sync2); // R8
    end else begin
      s_nxt.lvl_cnt = 2'd0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign irq.flag = s_r.flag;
  // request only once awake: a level gone by then gives a wake but no request
  assign irq.level_req = irq.enable & (gp_sense_t'(irq.sense) == GP_SNS_LOW) & ~s_r.sync2
                         & ~irq.deep_sleep;          // R3 R9 R10
  assign irq.wake = s_r.wake;

endmodule // gp_irq_sense

// ===== test/gp_pad_model.sv
// pad model for one port: resolves each pin from the block's drive and the outside circuit.
// assumes the outside drive and its enable come from the testbench.
`timescale 1ns/1ns

module gp_pad_model #(
  parameter int W = 8
) (
  // block side
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  // outside circuit
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  // resolved pins
  output logic      [W-1:0] pin
);
  // ==========================================================
  // resolution
  // released pins float high on a pull-up, never keep the last driven value
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin[i] = oe[i] ? out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule // gp_pad_model

// ===== test/gp_top_chk.sv
// checker for gp_top: apb timing and port register relations.
// assumes a bind to gp_top with pclk as its only clock.
`timescale 1ns/1ns

module gp_top_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and power
  input wire logic [7:0]  port_b_pin_in,
  input wire logic [7:0]  port_b_pin_oe,
  input wire logic [7:0]  port_d_pin_out,
  input wire logic        deep_sleep,
  input wire logic        wake
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // last written byte, kept so pin checks do not lean on the master holding pwdata
  logic [7:0] wd_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wd_r <= 8'h00;
    else if (pready && pwrite) wd_r <= pwdata[7:0];
  end

  // ==========================================================
  // assertions
  acc_ready_a: assert property (psel && penable && !pready |=> pready) else $error("no ready in access");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  ready_in_acc_a: assert property (pready |-> psel && penable) else $error("ready outside access");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  unmapped_err_a: assert property (pready && paddr > 8'h30 |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  dir_to_oe_a: assert property (pready && pwrite && paddr == 8'h04 |-> ##2 port_b_pin_oe == wd_r)
    else $error("direction not on enables");
  latch_to_out_a: assert property (pready && pwrite && paddr == 8'h18 |-> ##2 port_d_pin_out == wd_r)
    else $error("latch not on pins");
  pin_read_a: assert property (pready && !pwrite && paddr == 8'h08 && $stable(port_b_pin_in) &&
    port_b_pin_in == $past(port_b_pin_in, 2) && port_b_pin_in == $past(port_b_pin_in, 3)
    |-> prdata == {24'h00_0000, port_b_pin_in}) else $error("pin register not live");
  c_top_zero_a: assert property (pready && !pwrite && paddr inside {8'h0C, 8'h10, 8'h14}
    |-> prdata[31:7] == 25'h000_0000) else $error("port c bit 7 not zero");
  // wake is two flops behind the sleep level that let the sense unit sample the pin
  wake_sleep_a: assert property (wake |-> $past(deep_sleep, 2)) else $error("wake outside sleep");
endmodule // gp_top_chk

bind gp_top gp_top_chk gp_top_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .port_b_pin_in, .port_b_pin_oe, .port_d_pin_out, .deep_sleep, .wake);

// ===== test/tb_top.sv
// self-checking bench for gp_top: apb register tests and pin interrupt tests.
// assumes gp_pkg compiled first and the checker bound to gp_top.
`timescale 1ns/1ns

module tb_top;
  import gp_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
  logic        pready, pslverr, irq, wake, io_clk_run = 1, deep_sleep = 0, startup_done = 0;
  logic [7:0]  paddr = 8'h00, b_in, b_out, b_oe, d_in, d_out, d_oe;
  logic [7:0]  ext_b = 8'hFF, ext_d = 8'hFF, en_b = 8'h00, en_d = 8'hFF;
  logic [6:0]  c_in, c_out, c_oe, ext_c = 7'h55, en_c = 7'h7F;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic [1:0]  irq_ack = 2'b00;
  logic [7:0]  regs [6] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h18, 8'h1C};
  gp_sense_t   modes [3] = '{GP_SNS_FALL, GP_SNS_RISE, GP_SNS_ANY};
  int          n_mismatch = 0, total_checks = 0, n;

  gp_top gp_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .port_b_pin_in(b_in), .port_b_pin_out(b_out), .port_b_pin_oe(b_oe), .port_c_pin_in(c_in),
    .port_c_pin_out(c_out), .port_c_pin_oe(c_oe), .port_d_pin_in(d_in), .port_d_pin_out(d_out),
    .port_d_pin_oe(d_oe), .io_clk_run, .deep_sleep, .startup_done, .irq_ack, .irq, .wake);
  gp_pad_model #(.W(8)) pad_b_inst (.out(b_out), .oe(b_oe), .ext_val(ext_b), .ext_en(en_b), .pin(b_in));
  gp_pad_model #(.W(7)) pad_c_inst (.out(c_out), .oe(c_oe), .ext_val(ext_c), .ext_en(en_c), .pin(c_in));
  gp_pad_model #(.W(8)) pad_d_inst (.out(d_out), .oe(d_oe), .ext_val(ext_d), .ext_en(en_d), .pin(d_in));

  always #10 pclk = ~pclk;

  // ==========================================================
  // tasks
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      complete_run;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 8'h00);
    chk(rdat, exp);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic pin_a(input logic v);
    @(posedge pclk);
    ext_d[2] <= v;
  endtask
  task automatic pin_b(input logic v);
    @(posedge pclk);
    ext_d[3] <= v;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    cyc(16);
    presetn <= 1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    foreach (regs[i]) wr(regs[i], 8'hFF);
    foreach (regs[i]) rd(regs[i], (i == 2 || i == 3) ? 8'h7F : 8'hFF);
    chk(b_oe, 8'hFF);
    chk(c_out, 7'h7F);
    wr(8'h00, 8'hA5);
    rd(8'h08, 8'hA5);
    wr(8'h08, 8'h00);
    rd(8'h08, 8'hA5);
    en_b <= 8'hFF;
    ext_b <= 8'h3C;
    wr(8'h04, 8'h00);
    rd(8'h08, 8'h3C);
    rd(8'h14, 8'h7F);
    foreach (regs[i]) wr(regs[i], 8'h00);
    rd(8'h14, 8'h55);
    en_c <= 7'h00;
    rd(8'h14, 8'h7F);
    xfer(8'h40, 1'b0, 8'h00);
    chk(rerr, 1'b1);
    chk(rdat, 8'h00);
    $display("test registers done");
    // rising then falling edge in each edge mode; flag cleared by write and by service
    wr(8'h28, 8'h81);
    foreach (modes[i]) begin
      wr(8'h24, {6'h00, modes[i]});
      pin_a(0);
      wr(8'h30, 8'h07);
      pin_a(1);
      cyc(6);
      rd(8'h2C, modes[i] != GP_SNS_FALL);
      chk(irq, modes[i] != GP_SNS_FALL);
      wr(8'h30, 8'h01);
      rd(8'h2C, 8'h00);
      pin_a(0);
      cyc(6);
      rd(8'h2C, modes[i] != GP_SNS_RISE);
      @(posedge pclk);
      irq_ack <= 2'b01;
      @(posedge pclk);
      irq_ack <= 2'b00;
      cyc(2);
      rd(8'h2C, 8'h00);
    end
    $display("test edge modes done");
    // software raises the interrupt by driving the pin as output
    wr(8'h24, 8'h02);
    wr(8'h18, 8'h04);
    wr(8'h1C, 8'h04);
    cyc(6);
    wr(8'h30, 8'h07);
    wr(8'h18, 8'h00);
    cyc(6);
    rd(8'h2C, 8'h01);
    wr(8'h1C, 8'h00);
    pin_a(1);
    wr(8'h30, 8'h07);
    $display("test output pin done");
    // low level holds the request, gated by the global enable
    wr(8'h24, 8'h00);
    pin_a(0);
    cyc(6);
    chk(irq, 1'b1);
    rd(8'h2C, 8'h00);
    cyc(40);
    chk(irq, 1'b1);
    wr(8'h28, 8'h01);
    cyc(3);
    chk(irq, 1'b0);
    wr(8'h28, 8'h81);
    pin_a(1);
    cyc(6);
    chk(irq, 1'b0);
    $display("test level done");
    // edges are not seen while the io clock is halted
    io_clk_run <= 0;
    wr(8'h24, 8'h02);
    wr(8'h30, 8'h07);
    pin_a(0);
    cyc(6);
    rd(8'h2C, 8'h00);
    pin_a(1);
    cyc(6);
    io_clk_run <= 1;
    wr(8'h30, 8'h07);
    $display("test halted clock done");
    // level wake from deep sleep needs two watchdog samples
    deep_sleep <= 1;
    io_clk_run <= 0;
    wr(8'h24, 8'h00);
    wr(8'h28, 8'h85);
    pin_a(0);
    n = 0;
    while (wake !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(n > 45 && n < 300, 1'b1);
    deep_sleep <= 0;
    io_clk_run <= 1;
    rd(8'h2C, 8'h04);
    cyc(6);
    chk(irq, 1'b1);
    wr(8'h30, 8'h04);
    pin_a(1);
    $display("test wake done");
    // level passes both samples but is gone before waking ends: wake, no request
    deep_sleep <= 1;
    io_clk_run <= 0;
    wr(8'h28, 8'h81);
    pin_a(0);
    n = 0;
    while (wake !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(n < 300, 1'b1);
    pin_a(1);
    cyc(4);
    deep_sleep <= 0;
    io_clk_run <= 1;
    cyc(6);
    chk(irq, 1'b0);
    rd(8'h2C, 8'h04);
    wr(8'h30, 8'h04);
    $display("test wake no request done");
    // second input: rising edge only, flag b cleared by service
    wr(8'h24, 8'h0C);
    wr(8'h28, 8'h82);
    wr(8'h30, 8'h07);
    pin_b(0);
    cyc(6);
    rd(8'h2C, 8'h00);
    pin_b(1);
    cyc(6);
    rd(8'h2C, 8'h02);
    chk(irq, 1'b1);
    @(posedge pclk);
    irq_ack <= 2'b10;
    @(posedge pclk);
    irq_ack <= 2'b00;
    cyc(2);
    rd(8'h2C, 8'h00);
    chk(irq, 1'b0);
    $display("test second input done");
    complete_run;
  end
endmodule // tb_top
